// ---- membus_pkg.sv ----
// Shared constants and types for the processor memory bus control ends.
`default_nettype none
package membus_pkg;
    // Bus clock phase held by the processor end.
    typedef enum logic [0:0] {
        PH_ONE = 1'b0, // Clock low, may be stretched.
        PH_TWO = 1'b1  // Clock high, address for next cycle.
    } phase_e;
    // Forecast codes on request and sequential lines.
    localparam logic [1:0] CYC_N = 2'h0;
    localparam logic [1:0] CYC_S = 2'h1;
    localparam logic [1:0] CYC_I = 2'h2;
    localparam logic [1:0] CYC_C = 2'h3;
    // Mode code that means user mode.
    localparam logic [4:0] MODE_USER = 5'h10;
    // Word step for sequential detection.
    localparam logic [31:0] WORD_STEP = 32'h4;
    // Extra phase 1 clocks the controller adds.
    localparam logic [3:0] WAIT_NSEQ = 4'h2;
    localparam logic [3:0] WAIT_WRITE = 4'h2;
    localparam logic [3:0] WAIT_SEQ = 4'h0;
    // Memory array and page field.
    localparam int MEM_WORDS = 256;
    localparam int MEM_LSB = 2;
    localparam int MEM_MSB = 9;
    localparam int PAGE_LSB = 12;
    localparam int PAGE_MSB = 15;
endpackage
`default_nettype wire

// ---- membus_if.sv ----
// Pin bundle between the processor end and the memory controller end.
`default_nettype none
interface membus_if;
    logic [31:0] addr; // Address bus.
    logic xfer_direction_n; // High means write.
    logic byte_word_sel_n; // Low requests a byte.
    logic atomic_lock; // High across an exchange pair.
    logic opcode_fetch_n; // Low on instruction fetch.
    logic privilege_mode_n; // Low in user mode.
    logic addr_oe; // Processor drives the address group.
    logic [31:0] data_cpu; // Processor write data.
    logic data_cpu_oe; // Processor drives the data bus.
    logic [31:0] data_mem; // Controller read data.
    logic data_mem_oe; // Controller drives the data bus.
    logic [31:0] data_bus; // Resolved data lines.
    logic mem_request_n;
    logic burst_next_flag;
    logic copro_instr_n;
    logic core_drive_ind_n;
    logic [4:0] proc_mode_n;
    logic debug_ack;
    logic exec_skip_n;
    logic external_clock_out;
    logic scan_out_ms;
    logic scan_out_data;
    logic page_abort; // Abort from the memory manager.
    logic hold_cycle_n; // Wait input.
    logic drive_permit_n;
    logic data_drive_enable;
    logic addr_drive_enable;
    logic test_float_n;

    // A real clash cannot be shown without high impedance, so the core wins here.
    assign data_bus = data_cpu_oe ? data_cpu : (data_mem_oe ? data_mem : 32'h0);

    modport cpu (
        output addr, xfer_direction_n, byte_word_sel_n, atomic_lock, opcode_fetch_n,
        output privilege_mode_n, addr_oe, data_cpu, data_cpu_oe, mem_request_n,
        output burst_next_flag, copro_instr_n, core_drive_ind_n, proc_mode_n,
        output debug_ack, exec_skip_n, external_clock_out, scan_out_ms, scan_out_data,
        input data_bus, page_abort, hold_cycle_n, drive_permit_n, data_drive_enable,
        input addr_drive_enable, test_float_n
    );
    modport mem (
        input addr, xfer_direction_n, byte_word_sel_n, atomic_lock, opcode_fetch_n,
        input privilege_mode_n, addr_oe, data_cpu_oe, mem_request_n,
        input burst_next_flag, core_drive_ind_n, external_clock_out, data_bus,
        output data_mem, data_mem_oe, page_abort, hold_cycle_n, drive_permit_n,
        output data_drive_enable, addr_drive_enable, test_float_n
    );
endinterface
`default_nettype wire

// ---- membus_cpu.sv ----
// Processor end: cycle pacing, forecast, exchange lock and bus drive control.
`default_nettype none
module membus_cpu
    import membus_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    membus_if.cpu bus,
    input wire logic req_valid_in,
    output logic req_ready_out,
    input wire logic req_write_in,
    input wire logic req_exchange_in,
    input wire logic req_copro_in,
    input wire logic req_byte_in,
    input wire logic req_opfetch_in,
    input wire logic [31:0] req_addr_in,
    input wire logic [31:0] req_wdata_in,
    input wire logic [4:0] mode_in,
    input wire logic debug_ack_in,
    input wire logic exec_skip_in,
    input wire logic scan_ms_in,
    input wire logic scan_data_in,
    output logic rsp_valid_out,
    output logic rsp_write_out,
    output logic rsp_abort_out,
    output logic [31:0] rsp_rdata_out
);
    // Next sequential word address.
    function automatic logic [31:0] next_word(input logic [31:0] a);
        next_word = a + WORD_STEP;
    endfunction

    phase_e phase_ff; // Current clock phase.
    // The cycle being planned (decided at the end of phase 2 of the cycle two before it).
    logic plan_mem_ff, plan_write_ff, plan_lock_ff, plan_byte_ff, plan_op_ff;
    logic [31:0] plan_addr_ff;
    logic [31:0] plan_wdata_ff;
    // The cycle now on the bus.
    logic cur_mem_ff, cur_write_ff;
    // Pending second half of an exchange.
    logic swap_pend_ff;
    logic [31:0] swap_addr_ff;
    logic [31:0] swap_data_ff;
    // Last memory address for sequential detection.
    logic [31:0] last_addr_ff;
    logic last_mem_ff;
    // Address group and forecast registers.
    logic [31:0] addr_ff;
    logic dir_n_ff, bw_n_ff, lock_ff, opc_n_ff, trans_n_ff;
    logic mreq_n_ff, seq_ff, cpi_n_ff, core_n_ff;
    logic [31:0] dout_ff;
    logic [4:0] mode_n_ff;
    logic dbg_ff, exec_n_ff, sms_ff, sdat_ff;
    logic [31:0] rdata_ff;
    logic rsp_v_ff, rsp_w_ff, rsp_a_ff;

    // Edges that close each phase; a low wait freezes phase 1 like a held clock.
    logic end_ph1, end_ph2, take_req, seq_hit;
    assign end_ph1 = (phase_ff == PH_ONE) && bus.hold_cycle_n;
    assign end_ph2 = (phase_ff == PH_TWO);
    // New work is planned at the end of phase 2 unless the exchange write is owed.
    assign take_req = end_ph2 && !swap_pend_ff && req_valid_in;
    assign req_ready_out = end_ph2 && !swap_pend_ff;
    assign seq_hit = last_mem_ff && ((req_addr_in == next_word(last_addr_ff))
                     || (req_addr_in == last_addr_ff));

    // Phase sequencer; all but the status copies and the response strobe advance only on phase ends, so bus state holds however long wait stays low.
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            phase_ff <= PH_ONE;
        end else if (end_ph1) begin
            phase_ff <= PH_TWO;
        end else if (end_ph2) begin
            phase_ff <= PH_ONE;
        end
    end

    // Planning of the following cycle and the cycle-type forecast.
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            plan_mem_ff <= 1'b0;
            plan_write_ff <= 1'b0;
            plan_lock_ff <= 1'b0;
            plan_byte_ff <= 1'b0;
            plan_op_ff <= 1'b0;
            plan_addr_ff <= 32'h0;
            plan_wdata_ff <= 32'h0;
            mreq_n_ff <= 1'b1;
            seq_ff <= 1'b0;
            cpi_n_ff <= 1'b1;
        end else if (end_ph2) begin
            if (swap_pend_ff) begin
                // Write half of the exchange, same location, still locked.
                // The read's own abort is not known yet; the manager faults this write too.
                plan_mem_ff <= 1'b1;
                plan_write_ff <= 1'b1;
                plan_lock_ff <= 1'b1;
                plan_byte_ff <= 1'b0;
                plan_op_ff <= 1'b0;
                plan_addr_ff <= swap_addr_ff;
                plan_wdata_ff <= swap_data_ff;
                mreq_n_ff <= 1'b0;
                seq_ff <= 1'b1;
                cpi_n_ff <= 1'b1;
            end else if (take_req && !req_copro_in) begin
                // Memory cycle; the exchange always starts with a read.
                plan_mem_ff <= 1'b1;
                plan_write_ff <= req_write_in && !req_exchange_in;
                plan_lock_ff <= req_exchange_in;
                plan_byte_ff <= req_byte_in;
                plan_op_ff <= req_opfetch_in;
                plan_addr_ff <= req_addr_in;
                plan_wdata_ff <= req_wdata_in;
                mreq_n_ff <= 1'b0;
                seq_ff <= seq_hit;
                cpi_n_ff <= 1'b1;
            end else begin
                // Coprocessor transfer or idle.
                plan_mem_ff <= 1'b0;
                plan_write_ff <= 1'b0;
                plan_lock_ff <= 1'b0;
                plan_byte_ff <= 1'b0;
                plan_op_ff <= 1'b0;
                mreq_n_ff <= 1'b1;
                seq_ff <= take_req;
                cpi_n_ff <= !take_req;
            end
        end
    end

    // Exchange bookkeeping: the write half is owed once the read half is planned.
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            swap_pend_ff <= 1'b0;
            swap_addr_ff <= 32'h0;
            swap_data_ff <= 32'h0;
        end else if (end_ph2) begin
            if (take_req && req_exchange_in && !req_copro_in) begin
                swap_pend_ff <= 1'b1;
                swap_addr_ff <= req_addr_in;
                swap_data_ff <= req_wdata_in;
            end else begin
                swap_pend_ff <= 1'b0;
            end
        end
    end

    // Sequential tracking of the last memory address.
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            last_addr_ff <= 32'h0;
            last_mem_ff <= 1'b0;
        end else if (end_ph2) begin
            last_mem_ff <= plan_mem_ff;
            if (plan_mem_ff) begin
                last_addr_ff <= plan_addr_ff;
            end
        end
    end

    // Address group changes in phase 2, one cycle ahead.
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            addr_ff <= 32'h0;
            dir_n_ff <= 1'b0;
            bw_n_ff <= 1'b1;
            lock_ff <= 1'b0;
            opc_n_ff <= 1'b1;
            trans_n_ff <= 1'b1;
        end else if (end_ph1) begin
            addr_ff <= plan_addr_ff;
            dir_n_ff <= plan_write_ff;
            bw_n_ff <= !plan_byte_ff;
            lock_ff <= plan_lock_ff;
            opc_n_ff <= !plan_op_ff;
            trans_n_ff <= (mode_in != MODE_USER);
        end
    end

    // Cycle now on the bus, and the core-drive indicator for it.
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            cur_mem_ff <= 1'b0;
            cur_write_ff <= 1'b0;
            core_n_ff <= 1'b1;
            dout_ff <= 32'h0;
        end else if (end_ph2) begin
            cur_mem_ff <= plan_mem_ff;
            cur_write_ff <= plan_write_ff;
            // Data stands for the whole cycle it belongs to, never timed by the enables.
            dout_ff <= plan_wdata_ff;
            // Low from phase 1 of a write, high again at its end.
            core_n_ff <= !plan_write_ff;
        end
    end

    // Completion: abort is sampled at the end of each memory cycle, read data at the end of each read.
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            rsp_v_ff <= 1'b0;
            rsp_w_ff <= 1'b0;
            rsp_a_ff <= 1'b0;
            rdata_ff <= 32'h0;
        end else begin
            rsp_v_ff <= end_ph2 && cur_mem_ff;
            if (end_ph2 && cur_mem_ff) begin
                rsp_w_ff <= cur_write_ff;
                rsp_a_ff <= bus.page_abort;
                if (!cur_write_ff) begin
                    rdata_ff <= bus.data_bus;
                end
            end
        end
    end

    // Status outputs copied from the core side every clock.
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            mode_n_ff <= 5'h1f;
            dbg_ff <= 1'b0;
            exec_n_ff <= 1'b1;
            sms_ff <= 1'b0;
            sdat_ff <= 1'b0;
        end else begin
            mode_n_ff <= ~mode_in;
            dbg_ff <= debug_ack_in;
            exec_n_ff <= !exec_skip_in;
            sms_ff <= scan_ms_in;
            sdat_ff <= scan_data_in;
        end
    end

    // Float control is combinational so no scan register sits in its path.
    assign bus.addr_oe = bus.addr_drive_enable && bus.test_float_n;
    assign bus.data_cpu_oe = !core_n_ff && !bus.drive_permit_n
                             && bus.data_drive_enable && bus.test_float_n;
    assign bus.addr = addr_ff;
    assign bus.xfer_direction_n = dir_n_ff;
    assign bus.byte_word_sel_n = bw_n_ff;
    assign bus.atomic_lock = lock_ff;
    assign bus.opcode_fetch_n = opc_n_ff;
    assign bus.privilege_mode_n = trans_n_ff;
    assign bus.data_cpu = dout_ff;
    // These never float.
    assign bus.mem_request_n = mreq_n_ff;
    assign bus.burst_next_flag = seq_ff;
    assign bus.copro_instr_n = cpi_n_ff;
    assign bus.core_drive_ind_n = core_n_ff;
    assign bus.proc_mode_n = mode_n_ff;
    assign bus.debug_ack = dbg_ff;
    assign bus.exec_skip_n = exec_n_ff;
    assign bus.external_clock_out = phase_ff;
    assign bus.scan_out_ms = sms_ff;
    assign bus.scan_out_data = sdat_ff;
    assign rsp_valid_out = rsp_v_ff;
    assign rsp_write_out = rsp_w_ff;
    assign rsp_abort_out = rsp_a_ff;
    assign rsp_rdata_out = rdata_ff;
endmodule
`default_nettype wire

// ---- membus_mem.sv ----
// Memory controller end: protection, wait insertion, lock arbitration, bus turnaround.
`default_nettype none
module membus_mem
    import membus_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    membus_if.mem bus,
    input wire logic [15:0] wp_pages_in,
    input wire logic [15:0] sys_pages_in,
    input wire logic other_req_in,
    output logic other_grant_out,
    input wire logic addr_enable_in,
    input wire logic data_enable_in,
    input wire logic test_float_n_in,
    output logic fault_out
);
    logic [31:0] mem_arr [MEM_WORDS]; // Backing store.
    logic act_ff, wr_ff, abort_ff, hold_n_ff, mem_oe_ff, permit_n_ff, grant_ff;
    logic [31:0] a_ff;
    logic [31:0] rd_ff;
    logic [3:0] wait_ff;
    logic ok_ff; // Page check kept from the last non-sequential cycle.
    logic latch, is_n, is_s, bad, bad_sys;
    logic [3:0] pg;

    // The clock-high phase is ending on this edge: address and type are for the next cycle.
    assign latch = bus.external_clock_out;
    assign is_n = !bus.mem_request_n && !bus.burst_next_flag;
    assign is_s = !bus.mem_request_n && bus.burst_next_flag;
    assign pg = bus.addr[PAGE_MSB:PAGE_LSB];
    assign bad_sys = !bus.privilege_mode_n && sys_pages_in[pg];
    assign bad = (bus.xfer_direction_n && wp_pages_in[pg]) || bad_sys;

    // Cycle latch and protection check, translated only on non-sequential cycles.
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            act_ff <= 1'b0;
            wr_ff <= 1'b0;
            a_ff <= 32'h0;
            ok_ff <= 1'b1;
            abort_ff <= 1'b0;
        end else if (latch) begin
            act_ff <= is_n || is_s;
            wr_ff <= bus.xfer_direction_n;
            a_ff <= bus.addr;
            if (is_n) begin
                // Only the page privilege is kept; direction changes cycle by cycle.
                ok_ff <= !bad_sys;
                abort_ff <= bad;
            end else begin
                abort_ff <= is_s && (!ok_ff || bad);
            end
        end
    end

    // Waits stretch phase 1 only; the wait line moves only while the clock is low.
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            wait_ff <= 4'h0;
            hold_n_ff <= 1'b1;
        end else if (latch) begin
            if (is_n) begin
                wait_ff <= bus.xfer_direction_n ? WAIT_WRITE : WAIT_NSEQ;
                hold_n_ff <= 1'b0;
            end else if (is_s && bus.xfer_direction_n) begin
                wait_ff <= WAIT_WRITE;
                hold_n_ff <= 1'b0;
            end else begin
                wait_ff <= WAIT_SEQ;
                hold_n_ff <= 1'b1;
            end
        end else if (wait_ff > 4'h1) begin
            wait_ff <= wait_ff - 4'h1;
        end else begin
            wait_ff <= 4'h0;
            hold_n_ff <= 1'b1;
        end
    end

    // Array read at the latch and write at the end of the write cycle.
    always_ff @(posedge clk_sys_in) begin
        if (latch) begin
            rd_ff <= mem_arr[bus.addr[MEM_MSB:MEM_LSB]];
            if (act_ff && wr_ff && !abort_ff) begin
                mem_arr[a_ff[MEM_MSB:MEM_LSB]] <= bus.data_bus;
                // A read of the word written at this edge must not see the stale copy.
                if (a_ff[MEM_MSB:MEM_LSB] == bus.addr[MEM_MSB:MEM_LSB]) begin
                    rd_ff <= bus.data_bus;
                end
            end
        end
    end

    // Turnaround: drop our drive first, then permit the core; reclaim one clock after
    // the core stops, so a short read after a write still finds the bus driven.
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            mem_oe_ff <= 1'b1;
            permit_n_ff <= 1'b1;
        end else begin
            mem_oe_ff <= bus.core_drive_ind_n && !bus.data_cpu_oe;
            permit_n_ff <= bus.core_drive_ind_n || mem_oe_ff;
        end
    end

    // The other master is never granted while the exchange lock is up.
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            grant_ff <= 1'b0;
        end else begin
            grant_ff <= other_req_in && !bus.atomic_lock;
        end
    end

    assign bus.data_mem = rd_ff;
    assign bus.data_mem_oe = mem_oe_ff;
    assign bus.page_abort = abort_ff;
    assign bus.hold_cycle_n = hold_n_ff;
    assign bus.drive_permit_n = permit_n_ff;
    assign bus.data_drive_enable = data_enable_in;
    assign bus.addr_drive_enable = addr_enable_in;
    assign bus.test_float_n = test_float_n_in;
    // The registered grant lags the lock by a clock, so the live lock masks it too.
    assign other_grant_out = grant_ff && !bus.atomic_lock;
    assign fault_out = abort_ff;
endmodule
`default_nettype wire

// ---- membus_asserts.sv ----
// Concurrent checks on the pins between the processor end and the memory end.
`default_nettype none
module membus_asserts (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic addr_oe,
    input wire logic data_cpu_oe,
    input wire logic data_mem_oe,
    input wire logic xfer_direction_n,
    input wire logic atomic_lock,
    input wire logic core_drive_ind_n,
    input wire logic external_clock_out,
    input wire logic hold_cycle_n,
    input wire logic drive_permit_n,
    input wire logic data_drive_enable,
    input wire logic addr_drive_enable,
    input wire logic test_float_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // One clock domain, so clocking and reset are given once.
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    // The core drives data only while every enable agrees.
    drive_gate_a: assert property (
        data_cpu_oe |-> !core_drive_ind_n && !drive_permit_n && data_drive_enable && test_float_n)
        else $error("data driven without all enables");
    // Test float removes the core drive at once.
    float_data_a: assert property (!test_float_n |-> !data_cpu_oe)
        else $error("data driven while floated");
    // Two cycles allow for a registered address enable.
    float_addr_a: assert property (
        (!addr_drive_enable || !test_float_n) [*2] |-> !addr_oe)
        else $error("address group driven while disabled");
    // The exchange opens with a read.
    lock_read_a: assert property ($rose(atomic_lock) |-> !xfer_direction_n)
        else $error("exchange did not begin with a read");
    // The lock spans at least the read cycle and the write address phase.
    lock_span_a: assert property ($rose(atomic_lock) |-> atomic_lock [*4])
        else $error("lock dropped inside the exchange");
    // Core drive is only announced for a write.
    write_dir_a: assert property ($fell(core_drive_ind_n) |-> xfer_direction_n)
        else $error("core drive announced on a read");
    // Ending the announcement stops the drive in the same cycle.
    drive_end_a: assert property ($rose(core_drive_ind_n) |-> !data_cpu_oe)
        else $error("core still drives after write end");
    no_clash_a: assert property (!(data_cpu_oe && data_mem_oe))
        else $error("both ends drive the data bus");
    // Wait only ever stretches the low phase.
    wait_low_a: assert property (!hold_cycle_n |-> !external_clock_out)
        else $error("wait asserted in phase 2");
    phase_two_a: assert property (external_clock_out |=> !external_clock_out)
        else $error("phase 2 longer than one clock");
    // A stretched phase 1 still resumes within the longest wait.
    phase_back_a: assert property (
        $fell(external_clock_out) |-> ##[1:8] external_clock_out)
        else $error("phase 1 never ended");
    lock_c: cover property ($rose(atomic_lock));
    write_c: cover property ($fell(core_drive_ind_n));
    wait_c: cover property (!hold_cycle_n);
endmodule
`default_nettype wire

// ---- tb_cpu_memory_bus_control.sv ----
// Self-checking bench joining both bus ends, with a word memory model.
`default_nettype none
module tb_cpu_memory_bus_control;
    import membus_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic w; logic ab; logic [31:0] d;} exp_s;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic req_valid_in = 1'b0, req_ready_out, req_write_in = 1'b0, req_exchange_in = 1'b0;
    logic req_copro_in = 1'b0, req_byte_in = 1'b0, req_opfetch_in = 1'b0;
    logic [31:0] req_addr_in = 32'h0, req_wdata_in = 32'h0, rsp_rdata_out;
    logic [4:0] mode_in = 5'h13;
    logic debug_ack_in = 1'b0, exec_skip_in = 1'b0, scan_ms_in = 1'b0, scan_data_in = 1'b0;
    logic rsp_valid_out, rsp_write_out, rsp_abort_out, other_grant_out, fault_out;
    logic [15:0] wp_pages_in = 16'h0, sys_pages_in = 16'h0;
    logic other_req_in = 1'b0, addr_enable_in = 1'b1, data_enable_in = 1'b1;
    logic test_float_n_in = 1'b1;
    int fails = 0, samples_checked = 0, seed = 32'h6a2d29a8;
    int cyc_seen [4] = '{0, 0, 0, 0}; // Forecast codes observed.
    logic [31:0] mem_model [0:255]; // Expected memory contents.
    exp_s expq [$]; // Responses still owed, in order.
    membus_if i_membus_if ();
    membus_cpu i_membus_cpu (.clk_sys_in, .rst_in, .bus(i_membus_if), .req_valid_in,
        .req_ready_out, .req_write_in, .req_exchange_in, .req_copro_in, .req_byte_in,
        .req_opfetch_in, .req_addr_in, .req_wdata_in, .mode_in, .debug_ack_in,
        .exec_skip_in, .scan_ms_in, .scan_data_in, .rsp_valid_out, .rsp_write_out,
        .rsp_abort_out, .rsp_rdata_out);
    membus_mem i_membus_mem (.clk_sys_in, .rst_in, .bus(i_membus_if), .wp_pages_in,
        .sys_pages_in, .other_req_in, .other_grant_out, .addr_enable_in, .data_enable_in,
        .test_float_n_in, .fault_out);
    membus_asserts i_membus_asserts (.clk_sys_in, .rst_in, .addr_oe(i_membus_if.addr_oe),
        .data_cpu_oe(i_membus_if.data_cpu_oe), .data_mem_oe(i_membus_if.data_mem_oe),
        .xfer_direction_n(i_membus_if.xfer_direction_n), .atomic_lock(i_membus_if.atomic_lock),
        .core_drive_ind_n(i_membus_if.core_drive_ind_n),
        .external_clock_out(i_membus_if.external_clock_out),
        .hold_cycle_n(i_membus_if.hold_cycle_n), .drive_permit_n(i_membus_if.drive_permit_n),
        .data_drive_enable(i_membus_if.data_drive_enable),
        .addr_drive_enable(i_membus_if.addr_drive_enable),
        .test_float_n(i_membus_if.test_float_n));
    // The clock toggles every half period of 20 ns.
    always #20 clk_sys_in = ~clk_sys_in;
    task automatic fail(input string m);
        fails++;
        $display("Error at %0t: %s", $time, m);
    endtask
    task automatic results;
        $display("Checks made %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Settled outputs are judged at the falling edge, away from the launch edge.
    always @(negedge clk_sys_in) begin
        exp_s e;
        if (!rst_in) begin
            cyc_seen[{i_membus_if.mem_request_n, i_membus_if.burst_next_flag}]++;
            if (i_membus_if.atomic_lock === 1'b1 && other_grant_out !== 1'b0)
                fail("grant in lock");
            if (rsp_valid_out === 1'b1) begin
                samples_checked++;
                if (expq.size() == 0) fail("unexpected response");
                else begin
                    e = expq.pop_front();
                    if (rsp_write_out !== e.w || rsp_abort_out !== e.ab)
                        fail("bad response kind");
                    if (!e.w && !e.ab && rsp_rdata_out !== e.d)
                        fail("bad read data");
                end
            end
        end
    end
    // Kind 0 read, 1 write, 2 exchange, 3 coprocessor; expectations are queued first.
    task automatic req(input int k, input logic [31:0] a, input logic [31:0] d);
        int n;
        int ix;
        logic sab;
        logic wab;
        ix = a[9:2];
        sab = (mode_in == MODE_USER) && sys_pages_in[a[15:12]];
        wab = sab || wp_pages_in[a[15:12]];
        if (k == 0 || k == 2) expq.push_back('{1'b0, sab, mem_model[ix]});
        // The exchange write always follows; a faulted read faults it as well.
        if (k == 1 || k == 2) begin
            expq.push_back('{1'b1, wab, 32'h0});
            if (!wab) mem_model[ix] = d;
        end
        req_valid_in <= 1'b1;
        req_write_in <= (k == 1);
        req_exchange_in <= (k == 2);
        req_copro_in <= (k == 3);
        req_addr_in <= a;
        req_wdata_in <= d;
        req_opfetch_in <= 1'($random(seed));
        debug_ack_in <= 1'($random(seed));
        // The request is held until an edge that sees ready high.
        for (n = 0; n < 60; n++) begin
            @(negedge clk_sys_in);
            if (req_ready_out === 1'b1) break;
            @(posedge clk_sys_in);
        end
        @(posedge clk_sys_in);
        if (n == 60) fail("request not taken");
    endtask
    task automatic idle(input int n);
        req_valid_in <= 1'b0;
        repeat (n) @(posedge clk_sys_in);
    endtask
    initial begin
        #(40 * 20000);
        fail("watchdog expired");
        results();
    end
    initial begin
        repeat (4) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        idle(2);
        // Sequential word writes, then read back; seq_hit checks the address two requests back, so all forecast N cycles.
        for (int i = 0; i < 16; i++) req(1, 32'h100 + 4 * i, $random(seed));
        for (int i = 0; i < 16; i++) req(0, 32'h100 + 4 * i, 32'h0);
        idle(12);
        $display("Test fill and read back done");
        wp_pages_in <= 16'h00f0;
        sys_pages_in <= 16'h0f00;
        // Privileged then user traffic over protected and system pages.
        for (int p = 0; p < 2; p++) begin
            mode_in <= p ? MODE_USER : 5'h13;
            idle(10);
            samples_checked++;
            if (i_membus_if.privilege_mode_n !== (p == 0)) fail("bad privilege level");
            if (i_membus_if.proc_mode_n !== ~mode_in) fail("bad mode output");
            for (int i = 0; i < 30; i++) begin
                other_req_in <= 1'($random(seed));
                req($unsigned($random(seed)) % 4, 32'h100 | ($random(seed) & 32'hf03c),
                    $random(seed));
            end
            idle(20);
            $display("Test random traffic in mode set %0d done", p);
        end
        test_float_n_in <= 1'b0;
        idle(3);
        samples_checked++;
        if (i_membus_if.addr_oe !== 1'b0 || i_membus_if.data_cpu_oe !== 1'b0)
            fail("not floated");
        // The two group enables alone must float their groups as well.
        test_float_n_in <= 1'b1;
        addr_enable_in <= 1'b0;
        data_enable_in <= 1'b0;
        idle(3);
        samples_checked++;
        if (i_membus_if.addr_oe !== 1'b0 || i_membus_if.data_cpu_oe !== 1'b0)
            fail("enables ignored");
        addr_enable_in <= 1'b1;
        data_enable_in <= 1'b1;
        other_req_in <= 1'b1;
        idle(6);
        samples_checked++;
        if (other_grant_out !== 1'b1) fail("grant withheld outside lock");
        if (i_membus_if.addr_oe !== 1'b1) fail("address group not driven");
        if (expq.size() != 0) fail("responses missing");
        foreach (cyc_seen[c]) if (cyc_seen[c] == 0) fail("forecast code never seen");
        $display("Test float, grant and forecast done");
        results();
    end
endmodule
`default_nettype wire
